// ---- rtl/adc_seq_ctrl.sv ----
// sequencer, result placement and register file of a six-channel converter
// assumes the analog core converts one channel per start pulse and answers
// with a one-cycle done pulse; register port is a plain strobe port
//
// Functional notes
// - writing sequence control aborts running sequence
// - unsigned results, justify bit 7 left/right
// - length bits 6..3, reset length four
// - non-ring: nth result to nth register
// - ring: counter kept across scan restarts, cleared by a new start
// - ring scan wraps counter to register zero
// - counter readable in status register
// - abort or start clears counter always
// - per-register conversion complete flags
// - ring mode disables automatic compare
// - freeze field bits 1..0 selects freeze response
// - six inputs usable as pins or triggers
// - four external trigger inputs selectable as start
// - registers at system base plus offset
`include "adc_seq_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_seq_ctrl #(
   parameter int NUM_CH = 6,
   parameter int NUM_RES = 16,
   parameter int RES_W = 12,
   parameter logic [15:0] BASE_ADDR = 16'h0000
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   input wire logic freeze_req,
   input wire logic [3:0] ext_trigger_in,
   input wire logic [NUM_CH-1:0] analog_in_digital,
   output logic [NUM_CH-1:0] analog_in_digital_en,
   output var adc_seq_pkg::core_req_type core_req,
   input wire logic core_done,
   input wire logic [RES_W-1:0] core_data
);
   localparam int CW = $clog2(NUM_RES);

   adc_seq_pkg::reg_req_type req;
   adc_seq_pkg::seq_state_type state_q;
   logic [7:0] wrap_q, trig_q, irqc_q, seq_q, start_q, cmp_en_q, pin_q;
   logic [7:0] evt_mask_q;
   logic [`EVT_BITS-1:0] evt_q, evt_set;
   logic [NUM_RES-1:0] done_q;
   logic [15:0] res_q [NUM_RES];
   logic [CW-1:0] cc_q;
   logic [3:0] seq_cnt_q;
   logic [2:0] chan_q;
   logic [15:0] just_res;
   logic [3:0] seq_len;
   logic sel, wr_seq, wr_start, abort, go, ring, frozen;
   logic trig_s1_q, trig_s2_q, trig_last_q, trig_rise;
   logic [NUM_CH-1:0] pin_s1_q, pin_s2_q;
   logic [3:0] ext_s1_q, ext_s2_q;
   logic cmp_hit, last_conv, busy;

   // only the low byte of the window is decoded; base comes from the system
   assign sel = (reg_addr[15:8] == BASE_ADDR[15:8]);
   assign req = '{addr: reg_addr[7:0], wdata: reg_wdata,
                  wr: reg_wr & sel, rd: reg_rd & sel};
   assign wr_seq = req.wr && req.addr == `OFF_SEQ_CTRL;
   assign wr_start = req.wr && req.addr == `OFF_START_CTRL;
   assign abort = wr_seq;
   assign ring = seq_q[`BIT_RING];
   // zero length is treated as eight conversions
   assign seq_len = seq_q[`SEQ_LEN_HI:`SEQ_LEN_LO];
   // a nonzero freeze setting stalls between conversions only, so a frozen
   // conversion never sits on a leaking sample node
   assign frozen = freeze_req && seq_q[`FRZ_HI:`FRZ_LO] != `FRZ_RUN;
   assign busy = state_q != adc_seq_pkg::ST_IDLE;
   assign last_conv = (seq_len == 4'h0) ? (seq_cnt_q == 4'h7)
                                        : (seq_cnt_q == seq_len - 4'h1);

   // external trigger: a dedicated input or a channel pin, both synchronised
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_s1_q <= 4'h0;
         ext_s2_q <= 4'h0;
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         ext_s1_q <= ext_trigger_in;
         ext_s2_q <= ext_s1_q;
         pin_s1_q <= analog_in_digital;
         pin_s2_q <= pin_s1_q;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         trig_s2_q <= 1'b0;
         trig_last_q <= 1'b0;
      end else begin
         trig_last_q <= trig_s2_q;
         if (trig_q[`BIT_EXT_TRIG_SEL])
            trig_s2_q <= ext_s2_q[trig_q[1:0]];
         else if (trig_q[`TRIG_CH_HI:`TRIG_CH_LO] < 4'(NUM_CH))
            trig_s2_q <= pin_s2_q[trig_q[2:0]];
         else
            trig_s2_q <= 1'b0;
      end
   end
   assign trig_rise = trig_s2_q && !trig_last_q
                      && irqc_q[`BIT_EXT_TRIG_EN];
   assign go = wr_start || (trig_rise && !busy);
   assign analog_in_digital_en = pin_q[NUM_CH-1:0];

   // sequencer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= adc_seq_pkg::ST_IDLE;
         seq_cnt_q <= 4'h0;
         chan_q <= 3'h0;
      end else if (abort) begin
         state_q <= adc_seq_pkg::ST_IDLE;
         seq_cnt_q <= 4'h0;
      end else if (go) begin
         state_q <= adc_seq_pkg::ST_CONVERT;
         seq_cnt_q <= 4'h0;
         // a trigger has no write data, so it reuses the stored first channel
         chan_q <= wr_start ? req.wdata[2:0] : start_q[2:0];
      end else begin
         case (state_q)
            adc_seq_pkg::ST_IDLE: begin
               state_q <= adc_seq_pkg::ST_IDLE;
            end
            adc_seq_pkg::ST_CONVERT: begin
               if (!frozen)
                  state_q <= adc_seq_pkg::ST_WAIT;
            end
            adc_seq_pkg::ST_WAIT: begin
               if (core_done) begin
                  chan_q <= (chan_q == 3'(NUM_CH - 1)) ? 3'h0 : chan_q + 3'h1;
                  if (last_conv) begin
                     seq_cnt_q <= 4'h0;
                     state_q <= start_q[`BIT_SCAN] ? adc_seq_pkg::ST_CONVERT
                                                   : adc_seq_pkg::ST_IDLE;
                  end else begin
                     seq_cnt_q <= seq_cnt_q + 4'h1;
                     state_q <= adc_seq_pkg::ST_CONVERT;
                  end
               end
            end
            default: begin
               state_q <= adc_seq_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         core_req <= '0;
      else
         core_req <= '{start: state_q == adc_seq_pkg::ST_CONVERT && !frozen
                              && !abort,
                        channel: chan_q};
   end

   // conversion counter: result register index
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         cc_q <= '0;
      else if (abort || go)
         cc_q <= '0;
      else if (state_q == adc_seq_pkg::ST_WAIT && core_done) begin
         if (!ring && last_conv)
            cc_q <= '0;
         else if (cc_q == CW'(NUM_RES - 1))
            cc_q <= '0;
         else
            cc_q <= cc_q + CW'(1);
      end
   end

   // unsigned data, left or right aligned in a 16-bit result word
   assign just_res = seq_q[`BIT_JUSTIFY] ? 16'(core_data)
                     : {core_data, (16 - RES_W)'(0)};

   always_ff @(posedge ref_clk) begin
      if (state_q == adc_seq_pkg::ST_WAIT && core_done && !abort)
         res_q[cc_q] <= just_res;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         done_q <= '0;
      else if (abort || go)
         done_q <= '0;
      else if (state_q == adc_seq_pkg::ST_WAIT && core_done)
         done_q[cc_q] <= 1'b1;
   end

   // compare: result above zero for enabled registers, muted in ring mode
   assign cmp_hit = state_q == adc_seq_pkg::ST_WAIT && core_done && !ring
                    && irqc_q[`BIT_CMP_IRQ_EN]
                    && cmp_en_q[cc_q[2:0]] && just_res != 16'h0000;

   always_comb begin
      evt_set = '0;
      evt_set[`EVT_SEQ_DONE] = state_q == adc_seq_pkg::ST_WAIT && core_done
                               && last_conv;
      evt_set[`EVT_COMPARE] = cmp_hit;
      evt_set[`EVT_ABORT] = abort && busy;
   end

   // write one clears; a new event in the same cycle wins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         evt_q <= '0;
      else if (req.wr && req.addr == `OFF_EVT_STATUS)
         evt_q <= (evt_q & ~req.wdata[`EVT_BITS-1:0]) | evt_set;
      else
         evt_q <= evt_q | evt_set;
   end
   assign irq = |(evt_q & evt_mask_q[`EVT_BITS-1:0]);

   // control registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrap_q <= 8'h0F;
         trig_q <= 8'h0F;
         irqc_q <= 8'h00;
         seq_q <= `SEQ_CTRL_RESET;
         start_q <= 8'h00;
         cmp_en_q <= 8'h00;
         pin_q <= 8'h00;
         evt_mask_q <= 8'h00;
      end else if (req.wr) begin
         case (req.addr)
            `OFF_WRAP_CTRL: wrap_q <= {4'h0, req.wdata[3:0]};
            `OFF_TRIG_RES_CTRL: trig_q <= req.wdata;
            `OFF_IRQ_TRIG_CTRL: irqc_q <= {1'b0, req.wdata[6:0]};
            `OFF_SEQ_CTRL: seq_q <= req.wdata;
            `OFF_START_CTRL: start_q <= req.wdata;
            `OFF_CMP_EN: cmp_en_q <= req.wdata;
            `OFF_PIN_CFG: pin_q <= req.wdata;
            `OFF_EVT_MASK: evt_mask_q <= req.wdata;
            default: begin
            end
         endcase
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (!req.rd)
         reg_rdata <= 8'h00;
      else if (req.addr[7:4] == `OFF_RESULT_HI >> 4)
         reg_rdata <= res_q[CW'(req.addr[3:0])][15:8];
      else if (req.addr[7:4] == `OFF_RESULT_LO >> 4)
         reg_rdata <= res_q[CW'(req.addr[3:0])][7:0];
      else begin
         case (req.addr)
            `OFF_WRAP_CTRL: reg_rdata <= wrap_q;
            `OFF_TRIG_RES_CTRL: reg_rdata <= trig_q;
            `OFF_IRQ_TRIG_CTRL: reg_rdata <= irqc_q;
            `OFF_SEQ_CTRL: reg_rdata <= seq_q;
            `OFF_START_CTRL: reg_rdata <= start_q;
            `OFF_STATUS0: reg_rdata <= {busy, 3'h0, 4'(cc_q)};
            `OFF_CMP_EN: reg_rdata <= cmp_en_q;
            `OFF_CONV_DONE: reg_rdata <= done_q[7:0];
            `OFF_PIN_CFG: reg_rdata <= pin_q;
            `OFF_EVT_STATUS: reg_rdata <= 8'(evt_q);
            `OFF_EVT_MASK: reg_rdata <= evt_mask_q;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   chk_abort_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_seq |=> state_q == adc_seq_pkg::ST_IDLE)
      else $error("sequence not aborted by control write");

   chk_cc_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (abort || wr_start) |=> cc_q == '0)
      else $error("counter not cleared on abort or start");

   chk_ring_cmp: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ring |-> !evt_set[`EVT_COMPARE])
      else $error("compare active in ring mode");

   chk_seq_reset: assert property (@(posedge ref_clk)
      $rose(rst_n) |-> seq_len == 4'h4)
      else $error("default length not four");

   chk_done_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == adc_seq_pkg::ST_WAIT && core_done && !abort && !go)
      |=> done_q[$past(cc_q)])
      else $error("complete flag not set");

   chk_ring_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (ring && state_q == adc_seq_pkg::ST_WAIT && core_done && !abort && !go
       && cc_q != CW'(NUM_RES - 1)) |=> cc_q == $past(cc_q) + CW'(1))
      else $error("ring counter did not advance");

   chk_freeze_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      frozen |=> !core_req.start)
      else $error("conversion started while frozen");

   chk_nonring_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!ring && state_q == adc_seq_pkg::ST_WAIT && core_done && last_conv)
      |=> cc_q == '0)
      else $error("counter not reset at sequence end");

   chk_status_cc: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (req.rd && req.addr == `OFF_STATUS0)
      |=> reg_rdata[3:0] == $past(4'(cc_q)))
      else $error("status does not show counter");

   chk_flags_clear: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (abort || go) |=> done_q == '0)
      else $error("complete flags not cleared");

   chk_just_right: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state_q == adc_seq_pkg::ST_WAIT && core_done && !abort
       && seq_q[`BIT_JUSTIFY])
      |=> res_q[$past(cc_q)] == 16'($past(core_data)))
      else $error("right aligned result wrong");

   chk_just_left: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state_q == adc_seq_pkg::ST_WAIT && core_done && !abort
       && !seq_q[`BIT_JUSTIFY])
      |=> res_q[$past(cc_q)] == {$past(core_data), (16 - RES_W)'(0)})
      else $error("left aligned result wrong");

   chk_ext_start: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (trig_rise && !busy && !abort)
      |=> state_q == adc_seq_pkg::ST_CONVERT)
      else $error("trigger did not start a sequence");

   chk_trig_chan: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (trig_rise && !busy && !abort && !wr_start)
      |=> chan_q == $past(start_q[2:0]))
      else $error("trigger started on wrong channel");

   chk_base_ignore: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && !sel) |=> $stable(seq_q))
      else $error("write outside base changed control");

   chk_freeze_run: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state_q == adc_seq_pkg::ST_CONVERT
       && seq_q[`FRZ_HI:`FRZ_LO] == `FRZ_RUN && !abort && !go)
      |=> state_q == adc_seq_pkg::ST_WAIT)
      else $error("conversion held with freeze off");

   chk_ring_wrap: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (ring && state_q == adc_seq_pkg::ST_WAIT && core_done && !abort
       && !go && cc_q == CW'(NUM_RES - 1))
      |=> cc_q == '0)
      else $error("ring counter did not wrap");

   chk_abort_event: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (abort && busy) |=> evt_q[`EVT_ABORT])
      else $error("abort event not recorded");
endmodule

`default_nettype wire

// ---- rtl/adc_seq_defs.svh ----
// register offsets, field positions, reset values and counts of the
// sequence and result control block
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

`define OFF_WRAP_CTRL 8'h00
`define OFF_TRIG_RES_CTRL 8'h01
`define OFF_IRQ_TRIG_CTRL 8'h02
`define OFF_SEQ_CTRL 8'h03
`define OFF_START_CTRL 8'h05
`define OFF_STATUS0 8'h06
`define OFF_CMP_EN 8'h07
`define OFF_CONV_DONE 8'h08
`define OFF_PIN_CFG 8'h09
`define OFF_EVT_STATUS 8'h0A
`define OFF_EVT_MASK 8'h0B
`define OFF_RESULT_HI 8'h10
`define OFF_RESULT_LO 8'h20

`define SEQ_CTRL_RESET 8'h20
`define BIT_JUSTIFY 7
`define BIT_RING 2
`define SEQ_LEN_HI 6
`define SEQ_LEN_LO 3
`define FRZ_HI 1
`define FRZ_LO 0
`define BIT_SCAN 5
`define BIT_CMP_IRQ_EN 0
`define BIT_EXT_TRIG_EN 2
`define BIT_EXT_TRIG_SEL 7
`define TRIG_CH_HI 3
`define TRIG_CH_LO 0
`define EVT_SEQ_DONE 0
`define EVT_COMPARE 1
`define EVT_ABORT 2
`define EVT_BITS 3
`define FRZ_RUN 2'h0

`endif

// ---- rtl/adc_seq_pkg.sv ----
// types shared by the sequence and result control block
package adc_seq_pkg;
   typedef enum {
      ST_IDLE,
      ST_CONVERT,
      ST_WAIT
   } seq_state_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;

   typedef struct packed {
      logic start;
      logic [2:0] channel;
   } core_req_type;
endpackage

// ---- dv/adc_core_model.sv ----
// behavioural analog conversion core facing the sequence control block
// assumes one start pulse per conversion and no new start before done
`timescale 1ns/1ps
`default_nettype none

module adc_core_model (
   input wire logic ref_clk,
   input var adc_seq_pkg::core_req_type core_req,
   input wire logic [7:0] lat,
   output logic core_done,
   output logic [11:0] core_data
);
   logic [11:0] hist[$];
   logic [11:0] val;
   int n_start = 0;

   initial begin
      core_done = 1'b0;
      core_data = 12'h000;
      forever begin
         @(posedge ref_clk);
         if (core_req.start === 1'b1) begin
            n_start++;
            val = 12'(12'h0C3 + 12'h111 * n_start);
            repeat (lat) @(posedge ref_clk);
            core_done <= 1'b1;
            core_data <= val;
            hist.push_back(val);
            @(posedge ref_clk);
            core_done <= 1'b0;
            // stale data is inverted so a late sample cannot look right
            core_data <= ~val;
         end
      end
   end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench of the sequence and result control block
// assumes the core model answers every start after lat cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic freeze_req = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] lat = 8'h02;
   logic [3:0] ext_trigger_in = 4'h0;
   logic [5:0] analog_in_digital = 6'h15;
   logic [7:0] reg_rdata;
   logic [7:0] v;
   logic [5:0] analog_in_digital_en;
   logic irq;
   logic core_done;
   logic [11:0] core_data;
   adc_seq_pkg::core_req_type core_req;
   int error_cnt = 0;
   int checked = 0;
   int b;
   int n;
   logic [39:0] rows[5] = '{
      {16'h4001, 8'h83, 8'h01, 8'h83},
      {16'h400B, 8'h05, 8'h0B, 8'h05},
      {16'h4009, 8'h2A, 8'h09, 8'h2A},
      {16'h4203, 8'h11, 8'h03, 8'h20},
      {16'h400C, 8'hFF, 8'h0C, 8'h00}};

   adc_seq_ctrl #(.BASE_ADDR(16'h4000)) i_adc_seq_ctrl (.ref_clk(ref_clk),
      .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .freeze_req(freeze_req), .ext_trigger_in(ext_trigger_in),
      .analog_in_digital(analog_in_digital),
      .analog_in_digital_en(analog_in_digital_en), .core_req(core_req),
      .core_done(core_done), .core_data(core_data));
   adc_core_model i_adc_core_model (.ref_clk(ref_clk), .core_req(core_req),
      .lat(lat), .core_done(core_done), .core_data(core_data));

   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      // let the write settle before anyone samples a design output
      #1;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic wait_evt(input int bit_no);
      int i;
      for (i = 0; i < 600; i++) begin
         rd(16'h400A, v);
         if (v[bit_no] === 1'b1) break;
      end
      `CHK(v[bit_no], 1'b1)
   endtask

   task automatic run(input logic [7:0] ctrl, input logic [7:0] start);
      wr(16'h4003, ctrl);
      wr(16'h400A, 8'h07);
      wr(16'h4005, start);
      wait_evt(0);
   endtask

   // right justified keeps the word in the low bits, left in the high bits
   task automatic chk_res(input int idx, input logic [11:0] d, input bit rj);
      rd(16'h4010 + 16'(idx), v);
      `CHK(v, rj ? {4'h0, d[11:8]} : d[11:4])
      rd(16'h4020 + 16'(idx), v);
      `CHK(v, rj ? d[7:0] : {d[3:0], 4'h0})
   endtask

   task automatic wrap_up();
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #(40 * 30000);
      error_cnt++;
      wrap_up();
   end

   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(16'h4003, v);
      `CHK(v, 8'h20)
      rd(16'h4006, v);
      `CHK(v, 8'h00)
      `CHK(irq, 1'b0)
      foreach (rows[i]) begin
         wr(rows[i][39:24], rows[i][23:16]);
         rd({8'h40, rows[i][15:8]}, v);
         `CHK(v, rows[i][7:0])
      end
      `CHK(analog_in_digital_en, 6'h2A)
      wr(16'h400B, 8'h00);
      wr(16'h4007, 8'hFF);
      wr(16'h4002, 8'h01);
      b = i_adc_core_model.hist.size();
      run(8'h98, 8'h00);
      for (int i = 0; i < 3; i++) begin
         chk_res(i, i_adc_core_model.hist[b + i], 1'b1);
      end
      rd(16'h4008, v);
      `CHK(v[2:0], 3'h7)
      rd(16'h400A, v);
      `CHK(v[1], 1'b1)
      wr(16'h400B, 8'h01);
      `CHK(irq, 1'b1)
      wr(16'h400A, 8'h01);
      `CHK(irq, 1'b0)
      b = i_adc_core_model.hist.size();
      run(8'h08, 8'h00);
      chk_res(0, i_adc_core_model.hist[b], 1'b0);
      run(8'hA4, 8'h00);
      rd(16'h4006, v);
      `CHK(v, 8'h04)
      rd(16'h400A, v);
      `CHK(v[1], 1'b0)
      b = i_adc_core_model.hist.size();
      run(8'hA4, 8'h00);
      chk_res(0, i_adc_core_model.hist[b], 1'b1);
      // slow core leaves room to read status between conversions
      lat <= 8'h14;
      b = i_adc_core_model.hist.size();
      wr(16'h400A, 8'h07);
      wr(16'h4005, 8'h20);
      for (int i = 0; i < 900 && i_adc_core_model.hist.size() < b + 18; i++)
         @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
      rd(16'h4006, v);
      `CHK(v, 8'h82)
      wr(16'h4003, 8'hA4);
      rd(16'h4006, v);
      `CHK(v, 8'h00)
      rd(16'h400A, v);
      `CHK(v[2], 1'b1)
      chk_res(0, i_adc_core_model.hist[b + 16], 1'b1);
      chk_res(1, i_adc_core_model.hist[b + 17], 1'b1);
      repeat (30) @(posedge ref_clk);
      lat <= 8'h01;
      freeze_req <= 1'b1;
      n = i_adc_core_model.n_start;
      wr(16'h4003, 8'h21);
      wr(16'h400A, 8'h07);
      wr(16'h4005, 8'h00);
      repeat (20) @(posedge ref_clk);
      `CHK(i_adc_core_model.n_start, n)
      freeze_req <= 1'b0;
      wait_evt(0);
      `CHK(i_adc_core_model.n_start, n + 4)
      wr(16'h4001, 8'h82);
      wr(16'h4002, 8'h04);
      wr(16'h4003, 8'h20);
      wr(16'h400A, 8'h07);
      ext_trigger_in <= 4'h4;
      wait_evt(0);
      ext_trigger_in <= 4'h0;
      wrap_up();
   end
endmodule
`default_nettype wire
